//--- design/cmd_fifo.sv
// Small buffer between the character unpacker and the printer
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo
  import lpc_pkg::*;
#(
  parameter int W = ENTRY_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk, // Clock
  input wire logic arst_n, // Async reset, active low
  cmd_stream_if.snk in_s, // Filling side
  output logic out_valid, // Entry available
  output logic [W-1:0] out_data, // Head entry
  input wire logic out_ready, // Printer takes entry
  output logic empty // Nothing stored
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire logic do_wr;
  wire logic do_rd;

  assign in_s.ready = (count_reg != (AW+1)'(DEPTH));
  assign do_wr = in_s.valid && in_s.ready;
  assign do_rd = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign empty = (count_reg == '0);
  assign out_data = mem_reg[rd_ptr_reg];

  // ---------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      if (do_wr) begin
        mem_reg[wr_ptr_reg] <= in_s.data;
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : cmd_fifo
`default_nettype wire

//--- design/cmd_stream_if.sv
// Valid/ready stream carrying printer commands between modules
`timescale 1ns/1ps
`default_nettype none
interface cmd_stream_if #(
  parameter int W = 9
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : cmd_stream_if
`default_nettype wire

//--- design/lpc_pkg.sv
// Constants and types shared by the line printer control unit
package lpc_pkg;
  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int CHAR_W = 7;
  localparam int CHARS_PER_WORD = 5;
  localparam int WORD_W = 35;
  localparam int WORD_TOP_LSB = 28;
  localparam logic [2:0] LAST_CHAR_IDX = 3'h4;
  localparam int LINE_CHARS = 120;
  localparam int COL_W = 7;
  localparam int TAB_W = 5;
  localparam int TRACKS = 8;
  localparam int PIA_W = 3;
  localparam int PI_CHANNELS = 7;

  // ---------------------------------------------------------------
  // Character codes
  // ---------------------------------------------------------------
  localparam logic [6:0] CH_EOT = 7'h04;
  localparam logic [6:0] CH_HT = 7'h09;
  localparam logic [6:0] CH_LF = 7'h0a;
  localparam logic [6:0] CH_VT = 7'h0b;
  localparam logic [6:0] CH_FF = 7'h0c;
  localparam logic [6:0] CH_CR = 7'h0d;
  localparam logic [6:0] CH_DC0 = 7'h10;
  localparam logic [6:0] CH_DC4 = 7'h14;
  localparam logic [6:0] CH_SPACE = 7'h20;
  localparam logic [6:0] CH_DEL = 7'h7f;

  // ---------------------------------------------------------------
  // Format tape track indices (bit i of the tape input is track i+1)
  // ---------------------------------------------------------------
  localparam logic [2:0] TRK_FF = 3'h0;
  localparam logic [2:0] TRK_DC0 = 3'h1;
  localparam logic [2:0] TRK_VT = 3'h6;
  localparam logic [2:0] TRK_LF = 3'h7;

  // ---------------------------------------------------------------
  // Tab stop intervals selected by the rotary switch
  // ---------------------------------------------------------------
  localparam logic [4:0] TAB_8 = 5'h08;
  localparam logic [4:0] TAB_10 = 5'h0a;
  localparam logic [4:0] TAB_12 = 5'h0c;
  localparam logic [4:0] TAB_16 = 5'h10;
  localparam logic [4:0] TAB_20 = 5'h14;

  // ---------------------------------------------------------------
  // Printer command stream and reset values
  // ---------------------------------------------------------------
  localparam int OP_W = 2;
  localparam int ENTRY_W = OP_W + CHAR_W;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PRINT = 2'h2;
  localparam int FIFO_DEPTH = 2;
  localparam logic [2:0] PIA_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_UNPACK = 3'b011,
    ST_TAB = 3'b010,
    ST_SPACE = 3'b110
  } lpc_state_t;
endpackage : lpc_pkg

//--- design/printer_control_unit.sv
// Line printer control unit: unpacks data words into printer commands
`timescale 1ns/1ps
`default_nettype none
module printer_control_unit
  import lpc_pkg::*;
(
  input wire logic core_clk, // Clock, 25 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic cono_strobe, // Conditions-out command
  input wire logic [PIA_W-1:0] cono_pia, // Priority channel with conditions-out
  input wire logic datao_strobe, // Data-out command
  input wire logic [WORD_W-1:0] datao_word, // Five packed characters
  input wire logic [2:0] tab_select, // Tab switch: 0..4 = 8,10,12,16,20
  input wire logic printer_fault, // Printer inoperable
  input wire logic buffer_clear_done, // Printer buffer cleared
  input wire logic [TRACKS-1:0] tape_hole, // Format tape hole per track
  input wire logic cmd_ready, // Printer takes command
  output logic busy, // Busy flag
  output logic done, // Done flag
  output logic error, // Error flag
  output logic [PI_CHANNELS-1:0] pi_request, // Request on channels 1..7
  output logic buffer_clear, // Clear printer buffer
  output logic paper_advance, // Paper motion
  output logic cmd_valid, // Command available
  output logic [OP_W-1:0] cmd_op, // Write or print
  output logic [CHAR_W-1:0] cmd_char, // Character to write
  output logic [COL_W-1:0] column // Column counter
);
  lpc_state_t state_reg, state_next;
  logic [WORD_W-1:0] data_reg, data_next;
  logic [2:0] char_idx_reg, char_idx_next;
  logic [PIA_W-1:0] pia_reg, pia_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [COL_W-1:0] col_reg, col_next;
  logic [TAB_W-1:0] tabpos_reg, tabpos_next;
  logic [2:0] track_reg, track_next;
  logic push;
  logic [OP_W-1:0] push_op;
  logic [CHAR_W-1:0] push_char;
  logic adv;
  wire logic fifo_ready;
  wire logic fifo_empty;

  cmd_stream_if #(.W(ENTRY_W)) push_s ();

  // ---------------------------------------------------------------
  // Character decode
  // ---------------------------------------------------------------
  wire logic [CHAR_W-1:0] cur_ch = data_reg[WORD_W-1:WORD_TOP_LSB];
  wire logic is_graphic = (cur_ch >= CH_SPACE) && (cur_ch != CH_DEL);
  wire logic is_dc = (cur_ch >= CH_DC0) && (cur_ch <= CH_DC4);
  wire logic is_space_code = (cur_ch == CH_FF) || is_dc || (cur_ch == CH_VT) || (cur_ch == CH_LF);
  wire logic [2:0] dc_track = TRK_DC0 + 3'(cur_ch - CH_DC0);
  wire logic [2:0] sel_track = (cur_ch == CH_FF) ? TRK_FF :
                               (cur_ch == CH_VT) ? TRK_VT :
                               (cur_ch == CH_LF) ? TRK_LF : dc_track;
  wire logic last_char = (char_idx_reg == LAST_CHAR_IDX);
  wire logic [TAB_W-1:0] tab_stop = (tab_select == 3'h1) ? TAB_10 :
                                    (tab_select == 3'h2) ? TAB_12 :
                                    (tab_select == 3'h3) ? TAB_16 :
                                    (tab_select == 3'h4) ? TAB_20 : TAB_8;
  wire logic [TAB_W-1:0] tabpos_inc = tabpos_reg + 1'b1;
  wire logic tab_wrap = (tabpos_inc >= tab_stop);
  wire logic [TAB_W-1:0] tabpos_step = tab_wrap ? '0 : tabpos_inc;
  wire logic hole_seen = tape_hole[track_reg];

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign busy = busy_reg;
  assign done = done_reg;
  assign error = printer_fault;
  assign column = col_reg;
  assign buffer_clear = (state_reg == ST_CLEAR);
  assign paper_advance = (state_reg == ST_SPACE) && fifo_empty && !hole_seen;
  assign push_s.valid = push;
  assign push_s.data = {push_op, push_char};
  assign fifo_ready = push_s.ready;

  genvar gi;
  generate
    for (gi = 0; gi < PI_CHANNELS; gi++) begin : g_pi
      assign pi_request[gi] = (done_reg || printer_fault) && (pia_reg == PIA_W'(gi + 1));
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    data_next = data_reg;
    char_idx_next = char_idx_reg;
    pia_next = pia_reg;
    busy_next = busy_reg;
    done_next = done_reg;
    col_next = col_reg;
    tabpos_next = tabpos_reg;
    track_next = track_reg;
    push = 1'b0;
    push_op = OP_WRITE;
    push_char = CH_SPACE;
    adv = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (datao_strobe && done_reg) begin
          data_next = datao_word;
          char_idx_next = '0;
          done_next = 1'b0;
          busy_next = 1'b1;
          state_next = ST_UNPACK;
        end
      end
      ST_CLEAR: begin
        if (buffer_clear_done) begin
          busy_next = 1'b0;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_UNPACK: begin
        if (is_graphic) begin
          push = 1'b1;
          push_char = cur_ch;
          if (fifo_ready) begin
            col_next = col_reg + 1'b1;
            tabpos_next = tabpos_step;
            adv = 1'b1;
          end
        end else if (cur_ch == CH_HT) begin
          state_next = ST_TAB;
        end else if (is_space_code) begin
          push = 1'b1;
          push_op = OP_PRINT;
          if (fifo_ready) begin
            track_next = sel_track;
            state_next = ST_SPACE;
          end
        end else if (cur_ch == CH_CR) begin
          push = 1'b1;
          push_op = OP_PRINT;
          if (fifo_ready) begin
            col_next = '0;
            tabpos_next = '0;
            adv = 1'b1;
          end
        end else if (cur_ch == CH_EOT) begin
          busy_next = 1'b0;
          done_next = 1'b0;
          state_next = ST_IDLE;
        end else begin
          adv = 1'b1;
        end
      end
      ST_TAB: begin
        push = 1'b1;
        if (fifo_ready) begin
          col_next = col_reg + 1'b1;
          tabpos_next = tabpos_step;
          if (tab_wrap) begin
            adv = 1'b1;
          end
        end
      end
      ST_SPACE: begin
        if (fifo_empty && hole_seen) begin
          adv = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (adv) begin
      if (last_char) begin
        done_next = 1'b1;
        busy_next = 1'b0;
        state_next = ST_IDLE;
      end else begin
        data_next = {data_reg[WORD_TOP_LSB-1:0], CHAR_W'(0)};
        char_idx_next = char_idx_reg + 1'b1;
        state_next = ST_UNPACK;
      end
    end
    if (cono_strobe) begin
      data_next = '0;
      char_idx_next = '0;
      pia_next = cono_pia;
      col_next = '0;
      tabpos_next = '0;
      track_next = '0;
      busy_next = 1'b1;
      done_next = 1'b0;
      state_next = ST_CLEAR;
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      data_reg <= '0;
      char_idx_reg <= '0;
      pia_reg <= PIA_RESET;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      col_reg <= '0;
      tabpos_reg <= '0;
      track_reg <= '0;
    end else begin
      state_reg <= state_next;
      data_reg <= data_next;
      char_idx_reg <= char_idx_next;
      pia_reg <= pia_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      col_reg <= col_next;
      tabpos_reg <= tabpos_next;
      track_reg <= track_next;
    end
  end

  // ---------------------------------------------------------------
  // Command buffer toward the printer
  // ---------------------------------------------------------------
  wire logic [ENTRY_W-1:0] fifo_out;

  cmd_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_s(push_s),
    .out_valid(cmd_valid),
    .out_data(fifo_out),
    .out_ready(cmd_ready),
    .empty(fifo_empty)
  );

  assign cmd_op = fifo_out[ENTRY_W-1:CHAR_W];
  assign cmd_char = fifo_out[CHAR_W-1:0];
endmodule : printer_control_unit
`default_nettype wire

//--- dv/pcu_chk.sv
// Port checker for the printer control unit
`timescale 1ns/1ps
`default_nettype none
module pcu_chk
  import lpc_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic arst_n, // Async reset
  input wire logic cono_strobe, // Conditions-out
  input wire logic datao_strobe, // Data-out
  input wire logic printer_fault, // Printer inoperable
  input wire logic buffer_clear_done, // Clear finished
  input wire logic cmd_ready, // Printer takes command
  input wire logic busy, // Busy flag
  input wire logic done, // Done flag
  input wire logic error, // Error flag
  input wire logic [PI_CHANNELS-1:0] pi_request, // Requests
  input wire logic buffer_clear, // Buffer clear
  input wire logic paper_advance, // Paper motion
  input wire logic cmd_valid, // Command available
  input wire logic [OP_W-1:0] cmd_op, // Command op
  input wire logic [CHAR_W-1:0] cmd_char // Command char
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------
  // Flags, interrupt requests, paper motion and command hold
  // ---------------------------------------------------------------
  a_cono_start: assert property (cono_strobe |=> busy && !done && buffer_clear) else $error("cono start");
  a_clear_end: assert property (buffer_clear && buffer_clear_done && !cono_strobe |=> done && !busy && !buffer_clear)
    else $error("clear end");
  a_error_level: assert property (error == printer_fault) else $error("error level");
  a_word_take: assert property (datao_strobe && done && !cono_strobe |=> busy && !done) else $error("word take");
  a_done_idle: assert property (done |-> !busy) else $error("done with busy");
  a_irq_cause: assert property (|pi_request |-> done || error) else $error("irq cause");
  a_irq_single: assert property ($onehot0(pi_request)) else $error("irq channel");
  a_adv_empty: assert property (paper_advance |-> !cmd_valid && busy) else $error("advance early");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_op)
    && (cmd_op != OP_WRITE || $stable(cmd_char))) else $error("cmd hold");
  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  c_advance: cover property (paper_advance);
  c_stall: cover property (cmd_valid && !cmd_ready);
  c_done: cover property ($rose(done));
endmodule : pcu_chk
bind printer_control_unit pcu_chk pcu_chk_inst (.core_clk, .arst_n, .cono_strobe, .datao_strobe, .printer_fault,
  .buffer_clear_done, .cmd_ready, .busy, .done, .error, .pi_request, .buffer_clear, .paper_advance, .cmd_valid,
  .cmd_op, .cmd_char);
`default_nettype wire

//--- dv/printer_control_unit_tb.sv
// Self-checking bench for the printer control unit
`timescale 1ns/1ps
`default_nettype none
module printer_control_unit_tb;
  import lpc_pkg::*;
  logic core_clk, arst_n, cono_strobe, datao_strobe, printer_fault, buffer_clear_done, cmd_ready, stall;
  logic busy, done, error, buffer_clear, paper_advance, cmd_valid;
  logic [2:0] cono_pia, tab_select;
  logic [34:0] datao_word, hist;
  logic [7:0] tape_hole, hole_mask;
  logic [6:0] pi_request, column, cmd_char;
  logic [1:0] cmd_op;
  logic [15:0] wr_cnt, pr_cnt, adv_cnt, w0, p0, a0;
  int err_total, comparisons, cycles;
  printer_control_unit printer_control_unit_inst (.core_clk, .arst_n, .cono_strobe, .cono_pia, .datao_strobe,
    .datao_word, .tab_select, .printer_fault, .buffer_clear_done, .tape_hole, .cmd_ready, .busy, .done, .error,
    .pi_request, .buffer_clear, .paper_advance, .cmd_valid, .cmd_op, .cmd_char, .column);
  printer_model printer_model_inst (.core_clk, .arst_n, .buffer_clear, .paper_advance, .cmd_valid, .cmd_op,
    .cmd_char, .stall, .hole_mask, .buffer_clear_done, .cmd_ready, .tape_hole, .wr_cnt, .pr_cnt, .adv_cnt, .hist);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [34:0] exp, input logic [34:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic settle;
    int n;
    n = 0;
    while ((busy !== 1'b0 || cmd_valid !== 1'b0) && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk("busy", 35'h0, {34'h0, busy});
    chk("drained", 35'h0, {34'h0, cmd_valid});
  endtask : settle
  task automatic cono(input logic [2:0] pia);
    cono_pia = pia;
    cono_strobe = 1'b1;
    @(negedge core_clk);
    cono_strobe = 1'b0;
    @(negedge core_clk);
    settle;
  endtask : cono
  task automatic send(input logic [34:0] w);
    w0 = wr_cnt;
    p0 = pr_cnt;
    a0 = adv_cnt;
    datao_word = w;
    datao_strobe = 1'b1;
    @(negedge core_clk);
    datao_strobe = 1'b0;
    @(negedge core_clk);
  endtask : send
  task automatic test_done;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_start;
    chk("done", 35'h0, {34'h0, done});
    chk("pi", 35'h0, {28'h0, pi_request});
    cono(3'h3);
    chk("done", 35'h1, {34'h0, done});
    chk("pi", 35'h4, {28'h0, pi_request});
    chk("col", 35'h0, {28'h0, column});
  endtask : t_start
  task automatic t_word;
    stall = 1'b1;
    send({7'h41, 7'h42, 7'h43, 7'h44, 7'h45});
    repeat (10) @(negedge core_clk);
    chk("busy", 35'h1, {34'h0, busy});
    stall = 1'b0;
    settle;
    chk("chars", {7'h41, 7'h42, 7'h43, 7'h44, 7'h45}, hist);
    chk("col", 35'h5, {28'h0, column});
    chk("done", 35'h1, {34'h0, done});
  endtask : t_word
  task automatic t_ctrl;
    send({7'h01, 7'h46, 7'h7f, 7'h0d, 7'h47});
    settle;
    chk("chars", {21'h0, 7'h46, 7'h47}, {21'h0, hist[13:0]});
    chk("prints", {19'h0, p0 + 16'h1}, {19'h0, pr_cnt});
    chk("col", 35'h1, {28'h0, column});
    chk("adv", {19'h0, a0}, {19'h0, adv_cnt});
  endtask : t_ctrl
  task automatic t_tab;
    logic [4:0] stops [5] = '{TAB_8, TAB_10, TAB_12, TAB_16, TAB_20};
    for (int i = 0; i < 5; i++) begin
      tab_select = 3'(i);
      cono(3'h1);
      send({CH_HT, 28'h0});
      settle;
      chk("col", {30'h0, stops[i]}, {28'h0, column});
      chk("space", {28'h0, CH_SPACE}, {28'h0, hist[6:0]});
    end
  endtask : t_tab
  task automatic t_space;
    logic [6:0] codes [8] = '{CH_FF, CH_DC0, 7'h11, 7'h12, 7'h13, CH_DC4, CH_VT, CH_LF};
    logic [6:0] c0;
    for (int i = 0; i < 8; i++) begin
      hole_mask = 8'h01 << i;
      c0 = column;
      send({7'h48, codes[i], 7'h49, 14'h0});
      settle;
      chk("prints", {19'h0, p0 + 16'h1}, {19'h0, pr_cnt});
      chk("adv", {19'h0, a0 + 16'h2}, {19'h0, adv_cnt});
      chk("col", {28'h0, c0 + 7'h2}, {28'h0, column});
    end
  endtask : t_space
  task automatic t_eot;
    send({CH_EOT, 7'h41, 7'h42, 14'h0});
    settle;
    chk("done", 35'h0, {34'h0, done});
    chk("writes", {19'h0, w0}, {19'h0, wr_cnt});
    send({7'h41, 28'h0});
    settle;
    chk("writes", {19'h0, w0}, {19'h0, wr_cnt});
    printer_fault = 1'b1;
    @(negedge core_clk);
    chk("err", 35'h1, {34'h0, error});
    chk("pi", 35'h1, {28'h0, pi_request});
    printer_fault = 1'b0;
    @(negedge core_clk);
    chk("pi", 35'h0, {28'h0, pi_request});
  endtask : t_eot
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done;
    end
  end
  initial begin
    {arst_n, cono_strobe, datao_strobe, printer_fault, stall} = 5'h0;
    {cono_pia, tab_select, datao_word, hole_mask} = '0;
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    t_start;
    t_word;
    t_ctrl;
    t_tab;
    t_space;
    t_eot;
    test_done;
  end
endmodule : printer_control_unit_tb
`default_nettype wire

//--- dv/printer_model.sv
// Behavioural printer: buffer clear, command sink and format tape
`timescale 1ns/1ps
`default_nettype none
module printer_model
  import lpc_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic arst_n, // Async reset
  input wire logic buffer_clear, // Clear request
  input wire logic paper_advance, // Paper motion
  input wire logic cmd_valid, // Command available
  input wire logic [OP_W-1:0] cmd_op, // Command op
  input wire logic [CHAR_W-1:0] cmd_char, // Command char
  input wire logic stall, // Hold off commands
  input wire logic [TRACKS-1:0] hole_mask, // Punched tracks
  output logic buffer_clear_done, // Clear finished
  output logic cmd_ready, // Command taken
  output logic [TRACKS-1:0] tape_hole, // Holes under head
  output logic [15:0] wr_cnt, // Characters stored
  output logic [15:0] pr_cnt, // Lines printed
  output logic [15:0] adv_cnt, // Paper steps
  output logic [34:0] hist // Last five characters
);
  logic [2:0] clr_reg;
  logic [1:0] line_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_reg <= 3'h0;
      line_reg <= 2'h0;
      cmd_ready <= 1'b0;
      wr_cnt <= 16'h0;
      pr_cnt <= 16'h0;
      adv_cnt <= 16'h0;
      hist <= 35'h0;
    end else begin
      clr_reg <= buffer_clear ? clr_reg + 3'h1 : 3'h0;
      line_reg <= paper_advance ? line_reg + 2'h1 : 2'h0;
      adv_cnt <= adv_cnt + {15'h0, paper_advance};
      cmd_ready <= !stall;
      if (cmd_valid && cmd_ready && cmd_op == OP_WRITE) begin
        wr_cnt <= wr_cnt + 16'h1;
        hist <= {hist[27:0], cmd_char};
      end
      if (cmd_valid && cmd_ready && cmd_op == OP_PRINT) begin
        pr_cnt <= pr_cnt + 16'h1;
      end
    end
  end
  assign buffer_clear_done = clr_reg == 3'h4;
  // Hole comes under the head after two line steps
  assign tape_hole = (line_reg == 2'h2) ? hole_mask : '0;
endmodule : printer_model
`default_nettype wire
